// ### hdl/vof_pkg.sv
package vof_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0]  IDX_FMT        = 8'h15;
   localparam logic [7:0]  IDX_OUTCTL     = 8'h17;
   localparam logic [7:0]  IDX_HS_START   = 8'h21;
   localparam logic [7:0]  IDX_AV_START   = 8'h40;
   localparam logic [7:0]  IDX_AV_STOP    = 8'h42;
   localparam logic [7:0]  IDX_LINE_LEN   = 8'h50;
   localparam logic [7:0]  IDX_FIELD_LEN  = 8'h51;
   localparam logic [7:0]  IDX_VBLANK     = 8'h52;
   localparam logic [7:0]  IDX_STATUS     = 8'h53;
   // Format and output control register fields
   localparam int          FMT_SYNC_BIT   = 0;
   localparam int          FMT_422_BIT    = 1;
   localparam int          FMT_RANGE_LSB  = 2;
   localparam int          OUTCTL_DATA_BIT = 0;
   localparam int          OUTCTL_SOG_BIT = 1;
   // Reset values
   localparam logic [3:0]  FMT_RST        = 4'h0;
   localparam logic [1:0]  OUTCTL_RST     = 2'h3;
   localparam logic [7:0]  HS_START_RST   = 8'h0D;
   localparam logic [11:0] AV_START_RST   = 12'h12C;
   localparam logic [11:0] AV_STOP_RST    = 12'h62C;
   localparam logic [11:0] LINE_LEN_RST   = 12'h6B4;
   localparam logic [10:0] FIELD_LEN_RST  = 11'h107;
   localparam logic [7:0]  VBLANK_RST     = 8'h14;
   // Timing
   localparam int          LAT_444        = 18;
   localparam int          LAT_422        = 39;
   localparam logic [11:0] HS_WIDTH       = 12'h020;
   localparam logic [10:0] VS_LINES       = 11'h003;
   // Range select codes and limits
   localparam logic [1:0]  RNG_FULL       = 2'h0;
   localparam logic [1:0]  RNG_EXT        = 2'h1;
   localparam logic [1:0]  RNG_601        = 2'h2;
   localparam logic [9:0]  LIM_EXT_LO     = 10'h004;
   localparam logic [9:0]  LIM_EXT_HI     = 10'h3FB;
   localparam logic [9:0]  LIM_601_LO     = 10'h040;
   localparam logic [9:0]  LIM_601_Y_HI   = 10'h3AC;
   localparam logic [9:0]  LIM_601_C_HI   = 10'h3C0;
   localparam logic [9:0]  LIM_FULL_HI    = 10'h3FF;
   // Timing reference words
   localparam logic [9:0]  CODE_ONES      = 10'h3FF;
   localparam logic [9:0]  CODE_ZERO      = 10'h000;
   localparam logic [11:0] CODE_LEN       = 12'h004;
endpackage

// ### hdl/vof_delay.sv
`timescale 1ns/10ps
// Sample delay line with a short and a long tap
module vof_delay #(
   parameter int W     = 30,
   parameter int DEPTH = 39,
   parameter int TAP_S = 18
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] din,
   input  wire logic         sel_long,
   output logic      [W-1:0] dout
);
   logic [W-1:0] stage_q [DEPTH];

   // Stage i holds the sample taken i+1 clocks earlier
   generate
      for (genvar i = 0; i < DEPTH; i++) begin : g_stage
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               stage_q[i] <= '0;
            end else if (i == 0) begin
               stage_q[i] <= din;
            end else begin
               stage_q[i] <= stage_q[(i == 0) ? 0 : i-1];
            end
         end
      end
   endgenerate

   assign dout = sel_long ? stage_q[DEPTH-1] : stage_q[TAP_S-1];
endmodule

// ### hdl/vof_top.sv
`timescale 1ns/10ps
module vof_top (
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic             HREADYOUT,
   output logic      [31:0] HRDATA,
   output logic             HRESP,
   input  wire logic [9:0]  PIX_R_I,
   input  wire logic [9:0]  PIX_G_I,
   input  wire logic [9:0]  PIX_B_I,
   input  wire logic        SOG_I,
   output logic      [9:0]  RED_O,
   output logic             RED_OE,
   output logic      [9:0]  LUMA_O,
   output logic             LUMA_OE,
   output logic      [9:0]  BLUE_CHROMA_PORT,
   output logic             BLUE_CHROMA_OE,
   output logic             HSYNC_OUTPUT,
   output logic             VSYNC_OUTPUT,
   output logic             FIELD_ID_OUTPUT,
   output logic             PIXEL_DATA_CLOCK_OUT,
   output logic             SYNC_OE,
   output logic             SLICED_GREEN_SYNC_OUT,
   output logic             SOG_OE
);
   logic [3:0]  fmt_q;
   logic [1:0]  outctl_q;
   logic [7:0]  hs_start_q;
   logic [11:0] av_start_q;
   logic [11:0] av_stop_q;
   logic [11:0] line_len_q;
   logic [10:0] field_len_q;
   logic [7:0]  vblank_q;
   logic        wr_pend_q;
   logic [7:0]  wr_idx_q;
   logic [11:0] pix_cnt_q;
   logic [10:0] line_cnt_q;
   logic        field_q;
   logic        cr_phase_q;
   logic        code_out_q;
   logic        status_out_q;
   logic [5:0]  cfg_age_q;
   logic [29:0] tap;
   logic [7:0]  addr_idx;
   logic        addr_ok;
   logic [31:0] rdata_d;
   logic        sync_en;
   logic        mode_422;
   logic [1:0]  range_sel;
   logic        v_bit;
   logic        active;
   logic [9:0]  y_lo;
   logic [9:0]  y_hi;
   logic [9:0]  c_lo;
   logic [9:0]  c_hi;
   logic [9:0]  luma_d;
   logic [9:0]  chroma_d;
   logic        code_d;
   logic        status_d;

   assign sync_en   = fmt_q[vof_pkg::FMT_SYNC_BIT];
   assign mode_422  = fmt_q[vof_pkg::FMT_422_BIT];
   assign range_sel = fmt_q[vof_pkg::FMT_RANGE_LSB +: 2];
   assign addr_idx  = HADDR[9:2];
   assign addr_ok   = HSEL && HREADY && HTRANS[1];
   assign v_bit     = line_cnt_q < {3'h0, vblank_q};
   assign active    = (pix_cnt_q >= av_start_q) && (pix_cnt_q < av_stop_q);

   function automatic logic [9:0] clip(input logic [9:0] v, input logic [9:0] lo,
                                       input logic [9:0] hi);
      clip = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   function automatic logic [9:0] status_word(input logic f, input logic v, input logic h);
      status_word = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'b00};
   endfunction

   // AHB-Lite slave: zero wait states, always OKAY
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         wr_pend_q <= 1'b0;
         wr_idx_q  <= 8'h00;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end else begin
         wr_pend_q <= addr_ok && HWRITE;
         wr_idx_q  <= addr_idx;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         fmt_q       <= vof_pkg::FMT_RST;
         outctl_q    <= vof_pkg::OUTCTL_RST;
         hs_start_q  <= vof_pkg::HS_START_RST;
         av_start_q  <= vof_pkg::AV_START_RST;
         av_stop_q   <= vof_pkg::AV_STOP_RST;
         line_len_q  <= vof_pkg::LINE_LEN_RST;
         field_len_q <= vof_pkg::FIELD_LEN_RST;
         vblank_q    <= vof_pkg::VBLANK_RST;
      end else if (wr_pend_q) begin
         case (wr_idx_q)
            vof_pkg::IDX_FMT:       fmt_q       <= HWDATA[3:0];
            vof_pkg::IDX_OUTCTL:    outctl_q    <= HWDATA[1:0];
            vof_pkg::IDX_HS_START:  hs_start_q  <= HWDATA[7:0];
            vof_pkg::IDX_AV_START:  av_start_q  <= HWDATA[11:0];
            vof_pkg::IDX_AV_STOP:   av_stop_q   <= HWDATA[11:0];
            vof_pkg::IDX_LINE_LEN:  line_len_q  <= HWDATA[11:0];
            vof_pkg::IDX_FIELD_LEN: field_len_q <= HWDATA[10:0];
            vof_pkg::IDX_VBLANK:    vblank_q    <= HWDATA[7:0];
            default: ;
         endcase
      end
   end

   // Read data is latched in the address phase, so a read right after a write sees the old value
   always_comb begin
      rdata_d = 32'h0000_0000;
      case (addr_idx)
         vof_pkg::IDX_FMT:       rdata_d = {28'h0, fmt_q};
         vof_pkg::IDX_OUTCTL:    rdata_d = {30'h0, outctl_q};
         vof_pkg::IDX_HS_START:  rdata_d = {24'h0, hs_start_q};
         vof_pkg::IDX_AV_START:  rdata_d = {20'h0, av_start_q};
         vof_pkg::IDX_AV_STOP:   rdata_d = {20'h0, av_stop_q};
         vof_pkg::IDX_LINE_LEN:  rdata_d = {20'h0, line_len_q};
         vof_pkg::IDX_FIELD_LEN: rdata_d = {21'h0, field_len_q};
         vof_pkg::IDX_VBLANK:    rdata_d = {24'h0, vblank_q};
         vof_pkg::IDX_STATUS:    rdata_d = {19'h0, v_bit, field_q, line_cnt_q};
         default:                rdata_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         HRDATA <= 32'h0000_0000;
      end else if (addr_ok && !HWRITE) begin
         HRDATA <= rdata_d;
      end
   end

   // Output-side line, field and chroma phase counters
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pix_cnt_q  <= 12'h000;
         line_cnt_q <= 11'h000;
         field_q    <= 1'b0;
      end else if (pix_cnt_q >= line_len_q - 12'h001) begin
         pix_cnt_q <= 12'h000;
         if (line_cnt_q >= field_len_q - 11'h001) begin
            line_cnt_q <= 11'h000;
            field_q    <= ~field_q;
         end else begin
            line_cnt_q <= line_cnt_q + 11'h001;
         end
      end else begin
         pix_cnt_q <= pix_cnt_q + 12'h001;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cr_phase_q <= 1'b0;
      end else if (!active) begin
         cr_phase_q <= 1'b0;
      end else begin
         cr_phase_q <= ~cr_phase_q;
      end
   end

   vof_delay #(
      .W     (30),
      .DEPTH (vof_pkg::LAT_422),
      .TAP_S (vof_pkg::LAT_444)
   ) u_delay (
      .clk      (SYS_CLK),
      .rst_n    (RST_N),
      .din      ({PIX_R_I, PIX_G_I, PIX_B_I}),
      .sel_long (mode_422),
      .dout     (tap)
   );

   // Range limits
   always_comb begin
      y_lo = 10'h000;
      y_hi = vof_pkg::LIM_FULL_HI;
      c_lo = 10'h000;
      c_hi = vof_pkg::LIM_FULL_HI;
      case (range_sel)
         vof_pkg::RNG_EXT: begin
            y_lo = vof_pkg::LIM_EXT_LO;
            y_hi = vof_pkg::LIM_EXT_HI;
            c_lo = vof_pkg::LIM_EXT_LO;
            c_hi = vof_pkg::LIM_EXT_HI;
         end
         vof_pkg::RNG_601: begin
            y_lo = vof_pkg::LIM_601_LO;
            y_hi = vof_pkg::LIM_601_Y_HI;
            c_lo = vof_pkg::LIM_601_LO;
            c_hi = vof_pkg::LIM_601_C_HI;
         end
         default: ;
      endcase
   end

   // Pixel formatting and timing reference insertion
   always_comb begin
      luma_d   = clip(tap[19:10], y_lo, y_hi);
      chroma_d = clip((mode_422 && cr_phase_q) ? tap[29:20] : tap[9:0], c_lo, c_hi);
      code_d   = 1'b0;
      status_d = 1'b0;
      if (sync_en) begin
         if (pix_cnt_q == av_start_q - vof_pkg::CODE_LEN ||
             pix_cnt_q == av_stop_q) begin
            luma_d = vof_pkg::CODE_ONES;
            code_d = 1'b1;
         end else if (pix_cnt_q == av_start_q - 12'h003 || pix_cnt_q == av_start_q - 12'h002 ||
                      pix_cnt_q == av_stop_q + 12'h001 || pix_cnt_q == av_stop_q + 12'h002) begin
            luma_d = vof_pkg::CODE_ZERO;
            code_d = 1'b1;
         end else if (pix_cnt_q == av_start_q - 12'h001) begin
            luma_d   = status_word(field_q, v_bit, 1'b0);
            code_d   = 1'b1;
            status_d = 1'b1;
         end else if (pix_cnt_q == av_stop_q + 12'h003) begin
            luma_d   = status_word(field_q, v_bit, 1'b1);
            code_d   = 1'b1;
            status_d = 1'b1;
         end
         if (code_d) begin
            chroma_d = luma_d;
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         LUMA_O           <= 10'h000;
         BLUE_CHROMA_PORT <= 10'h000;
         RED_O            <= 10'h000;
         code_out_q       <= 1'b0;
         status_out_q     <= 1'b0;
      end else begin
         LUMA_O           <= luma_d;
         BLUE_CHROMA_PORT <= chroma_d;
         RED_O            <= mode_422 ? 10'h000 : clip(tap[29:20], c_lo, c_hi);
         code_out_q       <= code_d;
         status_out_q     <= status_d;
      end
   end

   // Sync outputs; the data clock is a toggle, so it runs at half the pixel rate
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         HSYNC_OUTPUT          <= 1'b0;
         VSYNC_OUTPUT          <= 1'b0;
         FIELD_ID_OUTPUT       <= 1'b0;
         PIXEL_DATA_CLOCK_OUT  <= 1'b0;
         SLICED_GREEN_SYNC_OUT <= 1'b0;
      end else begin
         HSYNC_OUTPUT          <= (pix_cnt_q >= {4'h0, hs_start_q}) &&
                                  (pix_cnt_q < {4'h0, hs_start_q} + vof_pkg::HS_WIDTH);
         VSYNC_OUTPUT          <= line_cnt_q < vof_pkg::VS_LINES;
         FIELD_ID_OUTPUT       <= field_q;
         PIXEL_DATA_CLOCK_OUT  <= ~PIXEL_DATA_CLOCK_OUT;
         SLICED_GREEN_SYNC_OUT <= SOG_I;
      end
   end

   // Output enables are low through reset, then follow the output control bits; RED_OE is also held low in 4:2:2 mode
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         LUMA_OE        <= 1'b0;
         BLUE_CHROMA_OE <= 1'b0;
         RED_OE         <= 1'b0;
         SYNC_OE        <= 1'b0;
         SOG_OE         <= 1'b0;
      end else begin
         LUMA_OE        <= outctl_q[vof_pkg::OUTCTL_DATA_BIT];
         BLUE_CHROMA_OE <= outctl_q[vof_pkg::OUTCTL_DATA_BIT];
         RED_OE         <= outctl_q[vof_pkg::OUTCTL_DATA_BIT] && !mode_422;
         SYNC_OE        <= outctl_q[vof_pkg::OUTCTL_DATA_BIT];
         SOG_OE         <= outctl_q[vof_pkg::OUTCTL_SOG_BIT];
      end
   end

   // Cycles since the last register write, for the latency checks
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cfg_age_q <= 6'h00;
      end else if (wr_pend_q) begin
         cfg_age_q <= 6'h00;
      end else if (cfg_age_q != 6'h3F) begin
         cfg_age_q <= cfg_age_q + 6'h01;
      end
   end

   a_red_hiz: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      mode_422 |=> !RED_OE)
      else $error("red outputs driven in 4:2:2 mode");

   a_sav_code: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (sync_en && pix_cnt_q == av_start_q - 12'h004 && !wr_pend_q && av_start_q > 12'h004)
      |=> LUMA_O == 10'h3FF ##1 LUMA_O == 10'h000 ##1 LUMA_O == 10'h000
          ##1 (LUMA_O[9] && !LUMA_O[6] && LUMA_O[1:0] == 2'b00))
      else $error("start code sequence wrong");

   a_eav_h_bit: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (sync_en && pix_cnt_q == av_stop_q && !wr_pend_q && av_stop_q + 12'h004 < line_len_q)
      |-> ##4 (LUMA_O[6] && status_out_q))
      else $error("end code H bit not set");

   a_prot_bits: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      status_out_q |-> (LUMA_O[5] == (LUMA_O[7] ^ LUMA_O[6])) &&
                       (LUMA_O[4] == (LUMA_O[8] ^ LUMA_O[6])) &&
                       (LUMA_O[3] == (LUMA_O[8] ^ LUMA_O[7])) &&
                       (LUMA_O[2] == (LUMA_O[8] ^ LUMA_O[7] ^ LUMA_O[6])))
      else $error("protection bits wrong");

   a_status_fv: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      status_out_q |-> LUMA_O[8] == $past(field_q) && LUMA_O[7] == $past(v_bit)
                       && $past(LUMA_O, 3) == 10'h3FF)
      else $error("status word F or V wrong");

   a_chroma_code: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      code_out_q |-> BLUE_CHROMA_PORT == LUMA_O)
      else $error("code missing on chroma");

   a_clip_ext: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (!code_out_q && $past(range_sel) == 2'h1) |-> LUMA_O >= 10'h004 && LUMA_O <= 10'h3FB)
      else $error("extended range exceeded");

   a_clip_601: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (!code_out_q && $past(range_sel) == 2'h2)
      |-> LUMA_O >= 10'h040 && LUMA_O <= 10'h3AC && BLUE_CHROMA_PORT <= 10'h3C0)
      else $error("601 range exceeded");

   a_lat_444: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (cfg_age_q > 6'h28 && fmt_q == 4'h0) |=> LUMA_O == $past(PIX_G_I, 19))
      else $error("4:4:4 latency wrong");

   a_lat_422: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (cfg_age_q > 6'h28 && fmt_q == 4'h2) |=> LUMA_O == $past(PIX_G_I, 40))
      else $error("4:2:2 latency wrong");

   a_hs_start: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (pix_cnt_q == {4'h0, hs_start_q} && !wr_pend_q) |=> HSYNC_OUTPUT [*8])
      else $error("hsync not at programmed start");

   a_oe_follow: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      $rose(RST_N) |-> !LUMA_OE && !SYNC_OE && !SOG_OE ##1 SOG_OE == $past(outctl_q[1]))
      else $error("output enable after reset wrong");

   c_sav_seen: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
      status_out_q && !LUMA_O[6]);
   c_eav_seen: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
      status_out_q && LUMA_O[6]);
   c_mode_422: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
      mode_422 && cr_phase_q);
   c_range_601: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
      range_sel == 2'h2 && sync_en);
endmodule

// ### tb/vof_sink.sv
`timescale 1ns/10ps
// Downstream receiver: finds timing reference codes in the luma stream
module vof_sink (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [9:0] luma,
   input  wire logic [9:0] chroma,
   input  wire logic       hsync,
   output int              sav_t,
   output int              eav_t,
   output int              hs_t,
   output logic      [9:0] sav_st,
   output logic      [9:0] eav_st,
   output int              code_cnt,
   output int              bad_c
);
   logic [39:0] yh;
   logic [39:0] ch;
   logic        hs_q;
   int          t;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         t        <= 0;
         code_cnt <= 0;
         bad_c    <= 0;
         hs_q     <= 1'b0;
      end else begin
         t    <= t + 1;
         yh   <= {yh[29:0], luma};
         ch   <= {ch[29:0], chroma};
         hs_q <= hsync;
         if (hsync && !hs_q) begin
            hs_t <= t;
         end
         // Stamp the first preamble word, four words back
         if (yh[39:10] == {10'h3FF, 20'h0} && yh[9]) begin
            code_cnt <= code_cnt + 1;
            if (ch !== yh) begin
               bad_c <= bad_c + 1;
            end
            if (yh[6]) begin
               eav_t  <= t - 4;
               eav_st <= yh[9:0];
            end else begin
               sav_t  <= t - 4;
               sav_st <= yh[9:0];
            end
         end
      end
   end
endmodule

// ### tb/video_output_formatter_tb_top.sv
`timescale 1ns/10ps
module video_output_formatter_tb_top;
   logic        clk;
   logic        rst_n;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [9:0]  pix_r;
   logic [9:0]  pix_g;
   logic [9:0]  pix_b;
   logic        sog;
   logic [31:0] cyc;
   logic        hready;
   logic [31:0] hrdata;
   logic [9:0]  luma;
   logic [9:0]  blue;
   logic        red_oe;
   logic        luma_oe;
   logic        blue_oe;
   logic        hs;
   logic        sync_oe;
   logic        sog_oe;
   logic [9:0]  red;
   logic        hresp;
   logic        vsync;
   logic        fid;
   logic        dclk;
   logic        sgo;
   logic [9:0]  sav_st;
   logic [9:0]  eav_st;
   int          sav_t;
   int          eav_t;
   int          hs_t;
   int          code_cnt;
   int          bad_c;
   int          err_total;
   int          cmp_count;
   vof_top vof_top_i (.SYS_CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
      .HREADYOUT(hready), .HRDATA(hrdata), .HRESP(hresp), .PIX_R_I(pix_r), .PIX_G_I(pix_g),
      .PIX_B_I(pix_b), .SOG_I(sog), .RED_O(red), .RED_OE(red_oe), .LUMA_O(luma),
      .LUMA_OE(luma_oe), .BLUE_CHROMA_PORT(blue), .BLUE_CHROMA_OE(blue_oe),
      .HSYNC_OUTPUT(hs), .VSYNC_OUTPUT(vsync), .FIELD_ID_OUTPUT(fid),
      .PIXEL_DATA_CLOCK_OUT(dclk), .SYNC_OE(sync_oe), .SLICED_GREEN_SYNC_OUT(sgo),
      .SOG_OE(sog_oe));
   vof_sink vof_sink_i (.clk(clk), .rst_n(rst_n), .luma(luma), .chroma(blue), .hsync(hs),
      .sav_t(sav_t), .eav_t(eav_t), .hs_t(hs_t), .sav_st(sav_st), .eav_st(eav_st),
      .code_cnt(code_cnt), .bad_c(bad_c));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Green pixel value equals the clock count, so latency shows directly
   always @(posedge clk) begin
      cyc   <= cyc + 1;
      pix_g <= 10'(cyc + 1);
      pix_b <= ~10'(cyc + 1);
      pix_r <= 10'(cyc + 6);
      sog   <= cyc[3];
   end
   task automatic final_report;
      $display("Mismatches %0d, comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {22'h0, idx, 2'h0};
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, idx, d, x);
   endtask
   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] x;
      ahb(1'b0, idx, 32'h0, x);
      chk(x, exp);
      chk({31'h0, hresp}, 32'h0);
   endtask
   function automatic logic [9:0] clip(input logic [9:0] v, input logic [9:0] lo,
                                       input logic [9:0] hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction
   function automatic logic [9:0] stat(input logic f, input logic v, input logic h);
      return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'b00};
   endfunction
   task automatic t_outctl;
      wr(vof_pkg::IDX_OUTCTL, 32'h1);
      repeat (3) @(negedge clk);
      chk({29'h0, sog_oe, sync_oe, luma_oe}, 32'h3);
      wr(vof_pkg::IDX_OUTCTL, 32'h2);
      repeat (3) @(negedge clk);
      chk({29'h0, sog_oe, sync_oe, luma_oe}, 32'h4);
      wr(vof_pkg::IDX_OUTCTL, 32'h3);
   endtask
   task automatic t_range(input logic [1:0] code, input logic [9:0] lo,
                          input logic [9:0] yhi, input logic [9:0] chi);
      wr(vof_pkg::IDX_FMT, {28'h0, code, 2'h0});
      repeat (40) @(posedge clk);
      repeat (1030) begin
         @(negedge clk);
         chk({22'h0, luma}, {22'h0, clip(10'(cyc - 19), lo, yhi)});
         chk({22'h0, blue}, {22'h0, clip(~10'(cyc - 19), lo, chi)});
         chk({22'h0, red}, {22'h0, clip(10'(cyc - 14), lo, chi)});
      end
   endtask
   task automatic t_lat422;
      int          p;
      int          ln;
      logic        cr;
      logic [31:0] c2;
      logic [3:0]  misc;
      wr(vof_pkg::IDX_FMT, 32'h2);
      repeat (60) @(posedge clk);
      // Shorter than the 436-cycle blanking gap; the run lies inside the active window, so both chroma phases are seen
      repeat (200) begin
         @(negedge clk);
         p    = int'((cyc - 32'd9) % 32'(vof_pkg::LINE_LEN_RST));
         ln   = int'((cyc - 32'd9) / 32'(vof_pkg::LINE_LEN_RST));
         c2   = cyc - 32'd2;
         // Cr on odd positions from the window start, Cb everywhere else
         cr   = (p >= int'(vof_pkg::AV_START_RST)) && (p < int'(vof_pkg::AV_STOP_RST)) &&
                ((p - int'(vof_pkg::AV_START_RST)) % 2 == 1);
         misc = {ln % int'(vof_pkg::FIELD_LEN_RST) < int'(vof_pkg::VS_LINES),
                 (ln / int'(vof_pkg::FIELD_LEN_RST)) % 2 == 1, cyc[0], c2[3]};
         chk({20'h0, blue_oe, red_oe, luma}, {20'h0, 2'b10, 10'(cyc - 40)});
         chk({22'h0, red}, 32'h0);
         chk({22'h0, blue}, {22'h0, cr ? 10'(cyc - 35) : ~10'(cyc - 40)});
         chk({28'h0, vsync, fid, dclk, sgo}, {28'h0, misc});
      end
   endtask
   task automatic t_sync;
      wr(vof_pkg::IDX_LINE_LEN, 32'd100);
      wr(vof_pkg::IDX_AV_START, 32'd20);
      wr(vof_pkg::IDX_AV_STOP, 32'd60);
      wr(vof_pkg::IDX_HS_START, 32'd5);
      // Range 01 keeps pixel data off 3FF, so no code can be faked
      wr(vof_pkg::IDX_FMT, 32'h5);
      repeat (400) @(posedge clk);
      chk(32'((eav_t - sav_t + 1000) % 100), 32'd44);
      chk(32'((hs_t - eav_t + 1000) % 100), 32'd45);
      chk({22'h0, sav_st}, {22'h0, stat(sav_st[8], sav_st[7], 1'b0)});
      chk({22'h0, eav_st}, {22'h0, stat(eav_st[8], eav_st[7], 1'b1)});
      chk(32'(bad_c), 32'h0);
      chk(32'(code_cnt > 5), 32'h1);
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      final_report();
   end
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata, sog} = '0;
      {cyc, pix_r, pix_g, pix_b} = '0;
      rst_n = 1'b0;
      repeat (4) @(negedge clk);
      chk({27'h0, luma_oe, blue_oe, red_oe, sync_oe, sog_oe}, 32'h0);
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(negedge clk);
      chk({27'h0, luma_oe, blue_oe, red_oe, sync_oe, sog_oe}, 32'h1F);
      rdchk(vof_pkg::IDX_FMT, 32'h0);
      rdchk(vof_pkg::IDX_OUTCTL, 32'h3);
      rdchk(vof_pkg::IDX_HS_START, 32'h0D);
      rdchk(vof_pkg::IDX_AV_START, 32'h12C);
      rdchk(vof_pkg::IDX_AV_STOP, 32'h62C);
      rdchk(8'h7F, 32'h0);
      t_outctl();
      t_range(2'h0, 10'h000, 10'h3FF, 10'h3FF);
      t_range(2'h1, 10'h004, 10'h3FB, 10'h3FB);
      t_range(2'h2, 10'h040, 10'h3AC, 10'h3C0);
      t_range(2'h3, 10'h000, 10'h3FF, 10'h3FF);
      t_lat422();
      t_sync();
      final_report();
   end
endmodule
